// >>> rer_pkg.sv
// Package with register map, field layout and types of the reliability error record.
`default_nettype none
package rer_pkg;
  localparam logic [15:0] OFS_FEATURES  = 16'h8E80;
  localparam logic [15:0] OFS_CONTROL   = 16'h8E88;
  localparam logic [15:0] OFS_SYNDROME  = 16'h8E90;
  localparam logic [15:0] OFS_INJECTION = 16'h8EC0;
  localparam logic [15:0] OFS_IRQ_STAT  = 16'h8EE0;
  localparam logic [15:0] OFS_IRQ_MASK  = 16'h8EE4;
  localparam logic [31:0] FEATURES_VAL  = 32'h0000_0081;
  localparam logic [31:0] CONTROL_RST   = 32'h0000_0008;
  localparam int          CTL_FIE_BIT   = 3;
  localparam int          SYN_VALID_BIT = 30;
  localparam int          SYN_OVF_BIT   = 27;
  localparam int          SYN_CE_LO     = 24;
  localparam int          SYN_SRC_LO    = 8;
  localparam int          INJ_WIDTH     = 4;
  localparam logic [1:0]  CE_CORRECTED  = 2'h2;
  localparam logic [1:0]  CE_CLEAR      = 2'h3;
  localparam logic [7:0]  CODE_NONE     = 8'h00;
  localparam logic [7:0]  CODE_TAG      = 8'h07;
  localparam logic [7:0]  CODE_DATA     = 8'h08;
  localparam logic [7:0]  SRC_CFG_CACHE = 8'h08;
  localparam logic [7:0]  SRC_MAX       = 8'h08;
  localparam int          IRQ_EVENTS    = 2;

  // One detected corrected error, as reported by a cache.
  typedef struct packed {
    logic       valid;
    logic [7:0] source_code;
    logic       data_err;
  } rer_event_s;

  // Syndrome record held by hardware.
  typedef struct packed {
    logic       valid;
    logic       overflow_flag;
    logic [1:0] ce;
    logic [7:0] source_code;
    logic [7:0] syndrome_code;
  } rer_record_s;
endpackage : rer_pkg
`default_nettype wire

// >>> rer_bank.sv
// Reliability error record register bank with an APB slave and fault interrupt.
//
// Local design decision: the APB interface to the registers.
`default_nettype none
module rer_bank #(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  input  wire logic [2:0]            pprot,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  nonsecure_reliability_access,
  input  wire logic                  cache_err_valid,
  input  wire logic [7:0]            cache_err_source,
  input  wire logic                  cache_err_data,
  output logic [3:0]                 inject_ctrl,
  output logic                       fault_irq,
  output logic                       event_irq
);
  // Refuse, at elaboration, an address width too narrow to reach the register window.
  if (ADDR_WIDTH < 16)
  begin : g_addr_check
    $error("ADDR_WIDTH must be at least 16");
  end

  // Error inputs come from cache logic on the same clock and are used directly.
  rer_pkg::rer_event_s  err_in;
  rer_pkg::rer_record_s rec;
  rer_pkg::rer_record_s next_rec;
  logic        fie;
  logic [3:0]  inj;
  logic        observed;
  logic [rer_pkg::IRQ_EVENTS-1:0] irq_stat;
  logic [rer_pkg::IRQ_EVENTS-1:0] irq_mask;

  assign err_in.valid       = cache_err_valid && (cache_err_source <= rer_pkg::SRC_MAX);
  assign err_in.source_code = cache_err_source;
  assign err_in.data_err    = cache_err_data;

  // Access decode; pprot[1] high marks a non-secure access.
  wire        acc_phase = psel && penable;
  wire        wr_en     = acc_phase && pwrite && (pstrb == 4'hF);
  wire        rd_en     = acc_phase && !pwrite;
  wire        ns_block  = pprot[1] && !nonsecure_reliability_access;
  wire [15:0] a16       = paddr[15:0];
  wire        hit_feat  = (a16 == rer_pkg::OFS_FEATURES);
  wire        hit_ctl   = (a16 == rer_pkg::OFS_CONTROL);
  wire        hit_syn   = (a16 == rer_pkg::OFS_SYNDROME);
  wire        hit_inj   = (a16 == rer_pkg::OFS_INJECTION);
  wire        hit_ist   = (a16 == rer_pkg::OFS_IRQ_STAT);
  wire        hit_imk   = (a16 == rer_pkg::OFS_IRQ_MASK);
  wire        mapped    = hit_feat | hit_ctl | hit_syn | hit_inj | hit_ist | hit_imk;
  wire        wr_ok     = wr_en && !ns_block;
  wire        wr_ctl    = wr_ok && hit_ctl;
  wire        wr_syn    = wr_ok && hit_syn;
  wire        wr_inj    = wr_ok && hit_inj;
  wire        wr_ist    = wr_en && hit_ist;
  wire        wr_imk    = wr_en && hit_imk;

  // Clear terms on the syndrome record; each is voided while a newly recorded
  // error has not yet been read, which stops software wiping an unseen error.
  wire w_v  = pwdata[rer_pkg::SYN_VALID_BIT];
  wire w_of = pwdata[rer_pkg::SYN_OVF_BIT];
  wire w_ce = (pwdata[rer_pkg::SYN_CE_LO +: 2] == rer_pkg::CE_CLEAR);
  wire clr_ok = wr_syn && observed && !err_in.valid;
  wire clr_of = clr_ok && w_of;
  wire clr_ce = clr_ok && w_ce && (!rec.overflow_flag || clr_of);
  wire clr_v  = clr_ok && w_v && ((rec.ce == 2'h0) || clr_ce);

  // Next record value; a new error wins over any clear in the same cycle.
  always_comb
  begin
    next_rec = rec;
    if (clr_of)
      next_rec.overflow_flag = 1'b0;
    if (clr_ce)
    begin
      next_rec.ce            = 2'h0;
      next_rec.source_code   = 8'h00;
      next_rec.syndrome_code = rer_pkg::CODE_NONE;
    end
    if (clr_v)
      next_rec.valid = 1'b0;
    if (err_in.valid)
    begin
      next_rec.valid = 1'b1;
      if (rec.ce != 2'h0)
        next_rec.overflow_flag = 1'b1;
      else
      begin
        next_rec.ce            = rer_pkg::CE_CORRECTED;
        next_rec.source_code   = err_in.source_code;
        next_rec.syndrome_code = err_in.data_err ? rer_pkg::CODE_DATA : rer_pkg::CODE_TAG;
      end
    end
  end

  // Record register; source field never takes bus data.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rec <= '0;
    else
      rec <= next_rec;
  end

  // Record checks. All but src_range_a, code_none_a and code_kind_a look at the registered record one edge after their cause,
  // so a new error and a clear in one cycle are judged by the error's outcome.
  valid_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_in.valid |=> rec.valid)
    else $error("record flag not set by a new error");

  ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in.valid && rec.ce != 2'h0) |=> rec.overflow_flag)
    else $error("overflow not set by a further error");

  ce_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in.valid && rec.ce == 2'h0) |=> (rec.ce == rer_pkg::CE_CORRECTED))
    else $error("corrected field not set to the corrected code");

  src_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in.valid && rec.ce == 2'h0) |=> (rec.source_code == $past(cache_err_source)))
    else $error("source field does not name the failing cache");

  src_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.ce != 2'h0) |-> (rec.source_code <= rer_pkg::SRC_MAX))
    else $error("source field holds an unknown cache code");

  data_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in.valid && rec.ce == 2'h0 && cache_err_data) |=>
      (rec.syndrome_code == rer_pkg::CODE_DATA))
    else $error("data error not recorded with the data code");

  tag_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in.valid && rec.ce == 2'h0 && !cache_err_data) |=>
      (rec.syndrome_code == rer_pkg::CODE_TAG))
    else $error("tag error not recorded with the tag code");

  code_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.ce == 2'h0) |-> (rec.syndrome_code == rer_pkg::CODE_NONE))
    else $error("syndrome code set while no error is recorded");

  code_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.ce != 2'h0) |-> (rec.syndrome_code == rer_pkg::CODE_TAG ||
                          rec.syndrome_code == rer_pkg::CODE_DATA))
    else $error("syndrome code neither tag nor data while recorded");

  keep_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.ce != 2'h0 && !clr_ce) |=> ($stable(rec.source_code) && $stable(rec.syndrome_code)))
    else $error("earliest error overwritten");

  src_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_syn && !clr_ce && !err_in.valid) |=> $stable(rec.source_code))
    else $error("source field took bus data");

  v_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.valid && rec.ce != 2'h0 && !clr_ce) |=> rec.valid)
    else $error("record cleared with corrected field set");

  valid_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_v |=> !rec.valid)
    else $error("accepted record clear had no effect");

  ovf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_of |=> !rec.overflow_flag)
    else $error("accepted overflow clear had no effect");

  ovf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.overflow_flag && !clr_of) |=> rec.overflow_flag)
    else $error("overflow dropped without a clearing write");

  ce_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rec.ce != 2'h0 && rec.overflow_flag && !clr_of) |=> (rec.ce != 2'h0))
    else $error("corrected field cleared while overflow stays set");

  ce_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_ce |=> (rec.ce == 2'h0))
    else $error("accepted corrected field clear had no effect");

  // Tracks whether software has read the record since the last new error.
  wire rd_syn = rd_en && hit_syn && !ns_block;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      observed <= 1'b1;
    else if (err_in.valid)
      observed <= 1'b0;
    else if (rd_syn)
      observed <= 1'b1;
  end

  // Race guard checks: a fresh error is always unseen, and while it is unseen
  // no clearing write may drop the valid flag or the overflow flag.
  unseen_mark_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_in.valid |=> !observed)
    else $error("new error not marked as unseen");

  unseen_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!observed && rec.overflow_flag) |=> rec.overflow_flag)
    else $error("overflow clear accepted before observation");

  unseen_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!observed && rec.valid) |=> rec.valid)
    else $error("record clear accepted before observation");

  // Control and injection registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fie <= rer_pkg::CONTROL_RST[rer_pkg::CTL_FIE_BIT];
      inj <= '0;
    end
    else
    begin
      if (wr_ctl)
        fie <= pwdata[rer_pkg::CTL_FIE_BIT];
      if (wr_inj)
        inj <= pwdata[rer_pkg::INJ_WIDTH-1:0];
    end
  end

  // Control checks. Blocked writes must leave control and injection untouched,
  // and an allowed write must take the enable bit exactly as written.
  ns_write_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && ns_block) |=> ($stable(fie) && $stable(inj)))
    else $error("blocked write changed control or injection");

  ctl_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && pwdata[rer_pkg::CTL_FIE_BIT]) |=> fie)
    else $error("interrupt enable not set by write");

  ctl_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && !pwdata[rer_pkg::CTL_FIE_BIT]) |=> !fie)
    else $error("interrupt enable not cleared by write");

  // Sticky event flags: 0 = error recorded, 1 = overflow. Set wins over clear.
  wire [rer_pkg::IRQ_EVENTS-1:0] ev_set = {err_in.valid && (rec.ce != 2'h0), err_in.valid};
  wire [rer_pkg::IRQ_EVENTS-1:0] ev_clr = wr_ist ? pwdata[rer_pkg::IRQ_EVENTS-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~ev_clr) | ev_set;
      if (wr_imk)
        irq_mask <= pwdata[rer_pkg::IRQ_EVENTS-1:0];
    end
  end

  // Event flag checks. Flags are sticky: only a one written to the status word
  // drops them, and a new event in that same cycle keeps them set.
  event_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_in.valid |=> irq_stat[0])
    else $error("error event flag not set");

  event_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    (err_in.valid && rec.ce != 2'h0) |=> irq_stat[1])
    else $error("overflow event flag not set");

  event_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_stat[0] && !ev_clr[0]) |=> irq_stat[0])
    else $error("error event flag dropped without a clear");

  event_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_clr[1] && !ev_set[1]) |=> !irq_stat[1])
    else $error("overflow event flag not cleared");

  // Read mux; blocked non-secure reads return zero, except reads of the interrupt status and mask words.
  wire [31:0] syn_word = {1'b0, rec.valid, 2'b00, rec.overflow_flag, 1'b0, rec.ce,
                          8'h00, rec.source_code, rec.syndrome_code};
  wire [31:0] rd_word  =
      hit_feat ? rer_pkg::FEATURES_VAL :
      hit_ctl  ? {28'h0, fie, 3'h0} :
      hit_syn  ? syn_word :
      hit_inj  ? {28'h0, inj} :
      hit_ist  ? {30'h0, irq_stat} :
      hit_imk  ? {30'h0, irq_mask} : 32'h0;
  wire [31:0] rd_val   = (ns_block && !hit_ist && !hit_imk) ? 32'h0 : rd_word;

  // APB answer: one access cycle, every output registered.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready    <= 1'b0;
      prdata    <= 32'h0;
      pslverr   <= 1'b0;
      fault_irq <= 1'b0;
      event_irq <= 1'b0;
      inject_ctrl <= '0;
    end
    else
    begin
      pready    <= psel && !penable;
      prdata    <= (psel && !penable && !pwrite) ? rd_val : prdata;
      pslverr   <= psel && !penable && !mapped;
      fault_irq <= fie && next_rec.valid;
      event_irq <= |(((irq_stat & ~ev_clr) | ev_set) & irq_mask);
      inject_ctrl <= wr_inj ? pwdata[rer_pkg::INJ_WIDTH-1:0] : inj;
    end
  end

  // Bus answer checks. Ready follows every setup cycle, so back-to-back transfers
  // with psel held high are answered as well as isolated ones.
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready after a setup cycle");

  ready_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable) |=> !pready)
    else $error("ready outside the access cycle");

  slverr_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> pslverr)
    else $error("no error for an unmapped address");

  slverr_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && mapped) |=> !pslverr)
    else $error("error for a mapped address");

  slverr_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");

  rdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read");

  feat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_feat && !ns_block) |=>
      (prdata == rer_pkg::FEATURES_VAL))
    else $error("feature value wrong");

  ns_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && ns_block && !hit_ist && !hit_imk) |=> (prdata == 32'h0))
    else $error("blocked read returned data");

  // Interrupt checks. The output lags the enable by one edge, so it is held
  // against the record of the edge at which it is sampled.
  fault_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    fie |=> (fault_irq == rec.valid))
    else $error("fault interrupt does not follow the record while enabled");

  fault_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fie |=> !fault_irq)
    else $error("fault interrupt high while disabled");

  inj_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    inject_ctrl == inj)
    else $error("injection output differs from the register");
endmodule : rer_bank
`default_nettype wire

// >>> rer_irq_ctrl.sv
// Interrupt controller model that counts rises of the fault interrupt level.
`default_nettype none
module rer_irq_ctrl (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fault_irq,
  output logic [7:0] irq_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  // A level source is counted once per rise, as an edge-latching controller would do.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last    <= 1'b0;
      irq_cnt <= 8'h00;
    end
    else
    begin
      last <= fault_irq;
      if (fault_irq && !last) irq_cnt <= irq_cnt + 8'h01;
    end
  end
endmodule : rer_irq_ctrl
`default_nettype wire

// >>> reliability_error_record_tb.sv
// Self-checking bench for the reliability error record bank.
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module reliability_error_record_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0]  pprot = 3'h0;
  logic        nsra = 1, cev = 0, ced = 0;
  logic [7:0]  ces = 8'h00;
  logic        pready, pslverr, fault_irq, event_irq;
  logic [31:0] prdata;
  logic [3:0]  inject_ctrl, v;
  logic [7:0]  irq_cnt, s;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  localparam logic [15:0] F = rer_pkg::OFS_FEATURES, C = rer_pkg::OFS_CONTROL;
  localparam logic [15:0] S = rer_pkg::OFS_SYNDROME, I = rer_pkg::OFS_INJECTION;
  rer_bank #(.ADDR_WIDTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .nonsecure_reliability_access(nsra), .cache_err_valid(cev), .cache_err_source(ces),
    .cache_err_data(ced), .inject_ctrl(inject_ctrl), .fault_irq(fault_irq),
    .event_irq(event_irq));
  rer_irq_ctrl irq (.pclk(pclk), .presetn(presetn), .fault_irq(fault_irq), .irq_cnt(irq_cnt));
  // Free-running clock at 8 ns.
  initial forever #4 pclk = ~pclk;
  // One APB transfer; every change lands just after a rising edge.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic ns);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // A read notes its expected answer first; the monitor below compares it.
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic ns);
    exp_q.push_back({2'b10, d});
    apb(1'b0, a, 32'h0, ns);
  endtask : rd
  // One corrected-error pulse, then time for record and interrupt to settle.
  task automatic err(input logic [7:0] src, input logic dat);
    @(posedge pclk);
    cev <= 1'b1; ces <= src; ced <= dat;
    @(posedge pclk);
    cev <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : err
  function automatic logic [31:0] syn(input logic ov, input logic [7:0] sr, input logic [7:0] cd);
    return 32'h4200_0000 | {4'h0, ov, 27'h0} | {16'h0, sr, cd};
  endfunction : syn
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Read results are judged here against the oldest note.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK("pslverr", e[32], pslverr)
      if (e[33]) `CHK("prdata", e[31:0], prdata)
    end
  // Hang guard: under two hundred cycles cover the whole sequence.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000) begin error_cnt++; close_out(); end
  end
  initial
  begin
    void'($urandom(32'h1b5d8cd1));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(F, 32'h81, 0);
    rd(C, 32'h8, 0);
    rd(S, 32'h0, 0);
    rd(I, 32'h0, 0);
    apb(1, F, 32'hFFFF_FFFF, 0);
    rd(F, 32'h81, 0);
    exp_q.push_back({2'b01, 32'h0});
    apb(0, 16'h8E84, 32'h0, 0);
    $display("done: reset and map");
    nsra <= 1'b0;
    rd(F, 32'h0, 1);
    apb(1, C, 32'h0, 1);
    apb(1, I, 32'h1, 1);
    rd(C, 32'h0, 1);
    nsra <= 1'b1;
    rd(C, 32'h8, 0);
    rd(I, 32'h0, 0);
    $display("done: access block");
    s = 8'($urandom_range(7, 0));
    err(s, 0);
    `CHK("fault_irq", 1'b1, fault_irq)
    `CHK("irq_cnt", 8'h01, irq_cnt)
    rd(S, syn(0, s, 8'h07), 1);
    err(8'h08, 1);
    rd(S, syn(1, s, 8'h07), 0);
    apb(1, S, 32'h4000_FF00, 0);
    apb(1, S, 32'h0300_0000, 0);
    rd(S, syn(1, s, 8'h07), 0);
    apb(1, S, 32'h0000_0000, 0);
    apb(1, S, 32'h0800_0000, 0);
    rd(S, syn(0, s, 8'h07), 0);
    apb(1, S, 32'h4300_0000, 0);
    rd(S, 32'h0, 0);
    `CHK("fault_irq", 1'b0, fault_irq)
    $display("done: record and clear");
    err(8'h08, 1);
    apb(1, S, 32'h4B00_0000, 0);
    rd(S, syn(0, 8'h08, 8'h08), 0);
    apb(1, C, 32'h0, 0);
    repeat (2) @(posedge pclk);
    `CHK("fault_irq", 1'b0, fault_irq)
    apb(1, C, 32'h8, 0);
    repeat (2) @(posedge pclk);
    `CHK("fault_irq", 1'b1, fault_irq)
    apb(1, S, 32'h4B00_0000, 0);
    rd(S, 32'h0, 0);
    $display("done: observe race");
    apb(1, C, 32'h0, 0);
    err(8'h02, 0);
    `CHK("fault_irq", 1'b0, fault_irq)
    rd(rer_pkg::OFS_IRQ_STAT, 32'h3, 0);
    // A mask bit of one lets its event through; the mask resets to all off.
    `CHK("event_irq", 1'b0, event_irq)
    apb(1, rer_pkg::OFS_IRQ_MASK, 32'h3, 0);
    repeat (2) @(posedge pclk);
    `CHK("event_irq", 1'b1, event_irq)
    apb(1, rer_pkg::OFS_IRQ_STAT, 32'h3, 0);
    repeat (2) @(posedge pclk);
    `CHK("event_irq", 1'b0, event_irq)
    rd(rer_pkg::OFS_IRQ_STAT, 32'h0, 0);
    apb(1, rer_pkg::OFS_IRQ_MASK, 32'h0, 0);
    $display("done: interrupts");
    repeat (3)
    begin
      v = 4'($urandom_range(15, 0));
      if (v[3]) v[2] = 1'b0;
      if (v[1]) v[0] = 1'b0;
      apb(1, I, {28'h0, v}, 0);
      rd(I, {28'h0, v}, 0);
      `CHK("inject_ctrl", v, inject_ctrl)
    end
    $display("done: injection");
    // A reset in mid-run must bring every register back to its reset value.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("inject_ctrl", 4'h0, inject_ctrl)
    `CHK("fault_irq", 1'b0, fault_irq)
    presetn <= 1'b1;
    rd(C, 32'h8, 0);
    rd(S, 32'h0, 0);
    rd(I, 32'h0, 0);
    rd(rer_pkg::OFS_IRQ_STAT, 32'h0, 0);
    $display("done: reset in run");
    close_out();
  end
endmodule : reliability_error_record_tb
`default_nettype wire
